// ### rtl/pwm_sd_pkg.sv
`default_nettype none
package pwm_sd_pkg;
   // Register byte addresses; the offsets are not printed, so they are chosen here
   localparam logic [7:0] ADDR_SD_SRC     = 8'h00;
   localparam logic [7:0] ADDR_TB_LOW     = 8'h04;
   localparam logic [7:0] ADDR_TB_HIGH    = 8'h08;
   localparam logic [7:0] ADDR_PH_LOW     = 8'h0c;
   localparam logic [7:0] ADDR_PH_HIGH    = 8'h10;
   localparam logic [7:0] ADDR_DUTY_LOW   = 8'h14;
   localparam logic [7:0] ADDR_DUTY_HIGH  = 8'h18;
   localparam logic [7:0] ADDR_PER_LOW    = 8'h1c;
   localparam logic [7:0] ADDR_PER_HIGH   = 8'h20;
   localparam logic [7:0] ADDR_SD_CTRL    = 8'h24;
   localparam logic [7:0] ADDR_SD_LEVEL   = 8'h28;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h2c;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h30;

   // Shutdown source fields
   localparam int         SRC_EXT_BIT   = 7;
   localparam logic [7:0] SD_SRC_MASK   = 8'h9e;
   localparam int         SRC_COMP_HI   = 4;     // Comparator 4 select
   localparam int         SRC_COMP_LO   = 1;     // Comparator 1 select
   localparam int         NUM_SD_SRC    = 5;     // Pin plus four comparators
   // Shutdown control fields
   localparam int         CTRL_STAT_BIT = 7;
   localparam int         CTRL_EN_BIT   = 6;
   localparam int         CTRL_ARS_BIT  = 5;
   localparam int         CTRL_PRST_BIT = 0;
   localparam logic [7:0] SD_CTRL_MASK  = 8'he1;
   // Interrupt status bits
   localparam int         IRQ_SD_BIT    = 0;
   localparam int         IRQ_PER_BIT   = 1;
   localparam logic [1:0] IRQ_MASK_BITS = 2'h3;

   // Reset values
   localparam logic [7:0]  TB_HIGH_RESET = 8'h01;
   localparam logic [15:0] TB_RESET      = {TB_HIGH_RESET, 8'h00};
endpackage : pwm_sd_pkg
`default_nettype wire

// ### rtl/sd_source_merge.sv
`timescale 1ns/1ns
`default_nettype none
// Gates each shutdown source with its select bit and ORs the result
module sd_source_merge #(
   parameter int N = 5
) (
   input  wire logic [N-1:0] sources,   // Raw source levels
   input  wire logic [N-1:0] selects,   // Per-source enables
   output logic              any_active // Any enabled source true
);
   logic [N-1:0] gated;                 // Enabled sources only
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_gate
         // Disabled sources are masked off
         assign gated[g] = sources[g] & selects[g];
      end
   endgenerate
   // Any one source is enough
   assign any_active = |gated;
endmodule : sd_source_merge
`default_nettype wire

// ### rtl/pwm_shutdown_timebase.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module pwm_shutdown_timebase #(
   parameter int OUT_W = 6
) (
   input  wire logic              pclk,                   // Module clock
   input  wire logic              presetn,                // Async reset, low
   input  wire logic              psel,                   // APB select
   input  wire logic              penable,                // APB access phase
   input  wire logic              pwrite,                 // APB direction
   input  wire logic [7:0]        paddr,                  // APB byte address
   input  wire logic [31:0]       pwdata,                 // APB write data
   output logic [31:0]            prdata,                 // APB read data
   output logic                   pready,                 // APB ready
   output logic                   pslverr,                // APB error
   input  wire logic              ext_trigger_input,      // External shutdown pin
   input  wire logic              comparator1_synced_out, // Comparator 1
   input  wire logic              comparator2_synced_out, // Comparator 2
   input  wire logic              comparator3_synced_out, // Comparator 3
   input  wire logic              comparator4_synced_out, // Comparator 4
   input  wire logic [OUT_W-1:0]  pwm_in,                 // Waveform from generator
   output logic [OUT_W-1:0]       pwm_out,                // Power stage drive
   output logic                   shutdown_active,        // Outputs held in shutdown
   output logic                   period_event,           // One-cycle period pulse
   output logic [15:0]            time_base_counter,      // Counter value
   output logic [15:0]            phase_value,            // Phase count
   output logic [15:0]            duty_value,             // Duty count
   output logic [15:0]            period_value,           // Period count
   output logic                   irq                     // Level interrupt
);
   import pwm_sd_pkg::*;

   logic [7:0]       sd_src;                // Shutdown source select
   logic             shutdown_enable;       // Auto-shutdown on
   logic             auto_restart_enable;   // Resume on its own
   logic             period_on_match_enable;// Match makes period event
   logic             shutdown_event_status; // Shutdown latched
   logic [OUT_W-1:0] sd_level;              // Levels driven in shutdown
   logic [1:0]       irq_status;            // Sticky events
   logic [1:0]       irq_mask;              // Interrupt enables
   logic             sd_trigger;            // Any enabled source true
   logic             wr_en;                 // Write strobe
   logic             rd_en;                 // Read strobe
   logic             period_match;          // Counter equals period
   logic [31:0]      next_rdata;            // Read mux

   // Write takes effect at the access edge; zero wait states
   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;

   // Address check used by the error flag
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a <= ADDR_IRQ_MASK) && (a[1:0] == 2'b00);
   endfunction : is_mapped

   // Unmapped addresses answer with an error
   assign pslverr = psel & penable & ~is_mapped(paddr);

   // Combine the five sources
   sd_source_merge #(.N(NUM_SD_SRC)) u_merge (
      .sources    ({ext_trigger_input, comparator4_synced_out, comparator3_synced_out,
                    comparator2_synced_out, comparator1_synced_out}),
      .selects    ({sd_src[SRC_EXT_BIT], sd_src[SRC_COMP_HI:SRC_COMP_LO]}),
      .any_active (sd_trigger)
   );

   // Source select; unimplemented bits never store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_src <= 8'h00;
      end else if (wr_en && paddr == ADDR_SD_SRC) begin
         sd_src <= pwdata[7:0] & SD_SRC_MASK;
      end
   end

   // Compare values written byte by byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_value  <= 16'h0000;
         duty_value   <= 16'h0000;
         period_value <= 16'h0000;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_PH_LOW:    phase_value[7:0]   <= pwdata[7:0];
            ADDR_PH_HIGH:   phase_value[15:8]  <= pwdata[7:0];
            ADDR_DUTY_LOW:  duty_value[7:0]    <= pwdata[7:0];
            ADDR_DUTY_HIGH: duty_value[15:8]   <= pwdata[7:0];
            ADDR_PER_LOW:   period_value[7:0]  <= pwdata[7:0];
            ADDR_PER_HIGH:  period_value[15:8] <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Shutdown control and output levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shutdown_enable        <= 1'b0;
         auto_restart_enable    <= 1'b0;
         period_on_match_enable <= 1'b0;
         sd_level               <= '0;
      end else if (wr_en) begin
         if (paddr == ADDR_SD_CTRL) begin
            shutdown_enable        <= pwdata[CTRL_EN_BIT];
            auto_restart_enable    <= pwdata[CTRL_ARS_BIT];
            period_on_match_enable <= pwdata[CTRL_PRST_BIT];
         end
         if (paddr == ADDR_SD_LEVEL) begin
            sd_level <= pwdata[OUT_W-1:0];
         end
      end
   end

   // Period match only counts while enabled
   assign period_match = period_on_match_enable && (time_base_counter == period_value);

   // Time base: software write wins over counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         time_base_counter <= TB_RESET;
      end else if (wr_en && paddr == ADDR_TB_LOW) begin
         time_base_counter[7:0] <= pwdata[7:0];
      end else if (wr_en && paddr == ADDR_TB_HIGH) begin
         time_base_counter[15:8] <= pwdata[7:0];
      end else if (period_match) begin
         time_base_counter <= 16'h0000;
      end else begin
         time_base_counter <= time_base_counter + 16'h0001;
      end
   end

   // Period event pulse, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_event <= 1'b0;
      end else begin
         period_event <= period_match;
      end
   end

   // Shutdown status: a live trigger beats any clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shutdown_event_status <= 1'b0;
      end else if (shutdown_enable && sd_trigger) begin
         shutdown_event_status <= 1'b1;
      end else if (auto_restart_enable) begin
         shutdown_event_status <= 1'b0;
      end else if (wr_en && paddr == ADDR_SD_CTRL) begin
         // Software may set or clear it by hand
         shutdown_event_status <= pwdata[CTRL_STAT_BIT];
      end
   end

   // Outputs held in shutdown until status clears
   assign shutdown_active = shutdown_event_status;

   // Drive registered waveform or the shutdown levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out <= '0;
      end else if (shutdown_enable && (sd_trigger || shutdown_event_status)) begin
         pwm_out <= sd_level;
      end else begin
         pwm_out <= pwm_in;
      end
   end

   // Sticky interrupt bits; a read clears them, but a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (i == IRQ_SD_BIT && shutdown_enable && sd_trigger) begin
               irq_status[i] <= 1'b1;
            end else if (i == IRQ_PER_BIT && period_match) begin
               irq_status[i] <= 1'b1;
            end else if (rd_en && paddr == ADDR_IRQ_STATUS && prdata[i]) begin
               // Only bits the reader was shown are cleared; a later one waits
               irq_status[i] <= 1'b0;
            end
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= 2'b00;
      end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
         irq_mask <= pwdata[1:0] & IRQ_MASK_BITS;
      end
   end

   // Level interrupt
   assign irq = |(irq_status & irq_mask);

   // Read mux; reserved bits and unmapped addresses give zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         ADDR_SD_SRC:     next_rdata[7:0] = sd_src & SD_SRC_MASK;
         ADDR_TB_LOW:     next_rdata[7:0] = time_base_counter[7:0];
         ADDR_TB_HIGH:    next_rdata[7:0] = time_base_counter[15:8];
         ADDR_PH_LOW:     next_rdata[7:0] = phase_value[7:0];
         ADDR_PH_HIGH:    next_rdata[7:0] = phase_value[15:8];
         ADDR_DUTY_LOW:   next_rdata[7:0] = duty_value[7:0];
         ADDR_DUTY_HIGH:  next_rdata[7:0] = duty_value[15:8];
         ADDR_PER_LOW:    next_rdata[7:0] = period_value[7:0];
         ADDR_PER_HIGH:   next_rdata[7:0] = period_value[15:8];
         ADDR_SD_CTRL:    next_rdata[7:0] = {shutdown_event_status, shutdown_enable,
                                             auto_restart_enable, 4'h0,
                                             period_on_match_enable};
         ADDR_SD_LEVEL:   next_rdata[OUT_W-1:0] = sd_level;
         ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
         ADDR_IRQ_MASK:   next_rdata[1:0] = irq_mask;
         default: ;
      endcase
   end

   // Read data leaves a flop: captured at the setup edge, shown in the access cycle.
   // It is one cycle older than a live read, the price of a glitch-free bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_rdata;    // Setup cycle of a read
      end else begin
         prdata <= 32'h0000_0000; // Idle, writes and the cycle after access
      end
   end

   // Checks on the logic above, all on the module clock and idle in reset

   // Shutdown noted in the status and in the sticky interrupt bit
   sequence seq_sd_flagged;
      shutdown_event_status && irq_status[IRQ_SD_BIT];
   endsequence

   // Counter back at zero with the period pulse beside it
   sequence seq_period_wrap;
      time_base_counter == 16'h0000 && period_event;
   endsequence

   // Unimplemented source bits never hold a one
   chk_src_reserved_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (sd_src & ~SD_SRC_MASK) == 8'h00)
      else $error("reserved source bits set");

   // The merge block must OR exactly the enabled sources
   chk_source_or: assert property (
      @(posedge pclk) disable iff (!presetn)
      sd_trigger == ((sd_src[SRC_EXT_BIT] && ext_trigger_input)
         || (|(sd_src[SRC_COMP_HI:SRC_COMP_LO] & {comparator4_synced_out,
         comparator3_synced_out, comparator2_synced_out, comparator1_synced_out}))))
      else $error("source merge wrong");

   // Enabled pin forces the levels one cycle later
   chk_ext_shutdown: assert property (
      @(posedge pclk) disable iff (!presetn)
      (shutdown_enable && sd_src[SRC_EXT_BIT] && ext_trigger_input)
      |=> shutdown_event_status && pwm_out == $past(sd_level))
      else $error("ext no shutdown");
   // Disabled pin alone leaves the status clear
   chk_ext_ignored: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!sd_src[SRC_EXT_BIT] && ext_trigger_input && !comparator1_synced_out
       && !comparator2_synced_out && !comparator3_synced_out && !comparator4_synced_out
       && !shutdown_event_status && !(wr_en && paddr == ADDR_SD_CTRL))
      |=> !shutdown_event_status)
      else $error("disabled source shut down");

   // Enabled comparator latches status and the interrupt bit
   chk_comp_shutdown: assert property (
      @(posedge pclk) disable iff (!presetn)
      (shutdown_enable && (|(sd_src[SRC_COMP_HI:SRC_COMP_LO] & {comparator4_synced_out,
       comparator3_synced_out, comparator2_synced_out, comparator1_synced_out})))
      |=> seq_sd_flagged)
      else $error("comp no shutdown");

   // Counter halves take the written byte
   chk_tb_write_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_TB_LOW) |=> time_base_counter[7:0] == $past(pwdata[7:0]))
      else $error("counter low write lost");
   chk_tb_write_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_TB_HIGH) |=> time_base_counter[15:8] == $past(pwdata[7:0]))
      else $error("counter high write lost");

   // Compare values keep the written byte
   chk_period_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_PER_HIGH) |=> period_value[15:8] == $past(pwdata[7:0]))
      else $error("period high write lost");
   chk_duty_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_DUTY_LOW) |=> duty_value[7:0] == $past(pwdata[7:0]))
      else $error("duty low write lost");
   chk_phase_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_PH_HIGH) |=> phase_value[15:8] == $past(pwdata[7:0]))
      else $error("phase high write lost");

   // Levels stay forced while the status holds
   chk_levels_forced: assert property (
      @(posedge pclk) disable iff (!presetn)
      (shutdown_enable && shutdown_event_status) |=> pwm_out == $past(sd_level))
      else $error("shutdown levels not driven");
   // With shutdown off the waveform passes, one cycle late
   chk_levels_free: assert property (
      @(posedge pclk) disable iff (!presetn)
      !shutdown_enable |=> pwm_out == $past(pwm_in))
      else $error("waveform not passed");

   // A status read clears what it returned, unless a new event lands
   chk_status_read_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == ADDR_IRQ_STATUS && !(shutdown_enable && sd_trigger) && !period_match)
      |=> (irq_status & $past(prdata[1:0])) == 2'b00)
      else $error("status read did not clear");
   // Auto-restart drops the status once no source is left
   chk_auto_restart: assert property (
      @(posedge pclk) disable iff (!presetn)
      (auto_restart_enable && !sd_trigger) |=> !shutdown_event_status)
      else $error("no auto restart");

   // Without auto-restart only software ends the shutdown
   chk_manual_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!auto_restart_enable && shutdown_event_status && !(wr_en && paddr == ADDR_SD_CTRL))
      |=> shutdown_event_status)
      else $error("status dropped by itself");
   // A match wraps the counter and pulses the event
   chk_period_match: assert property (
      @(posedge pclk) disable iff (!presetn)
      (period_match && !wr_en) |=> seq_period_wrap)
      else $error("period match missed");
   // No pulse while matching is off
   chk_no_match_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      !period_on_match_enable |=> !period_event)
      else $error("period pulse while off");
endmodule : pwm_shutdown_timebase
`default_nettype wire

// ### verification/sd_partner.sv
`timescale 1ns/1ns
`default_nettype none
// Stands in for the comparators, the shutdown pin and the waveform source
module sd_partner (
   input  wire logic       pclk,    // Module clock
   input  wire logic       presetn, // Async reset, low
   input  wire logic [4:0] level,   // Wanted levels: comparators 1..4, pin at 4
   output logic [4:0]      src,     // Synchronized source levels
   output logic [5:0]      wave     // Waveform, changes every cycle
);
   // Sources change only on the clock, as the synchronizers would deliver them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src  <= 5'h00;
         wave <= 6'h00;
      end else begin
         src  <= level;
         // Counting keeps a stale output from passing for a fresh one
         wave <= wave + 6'h01;
      end
   end
endmodule : sd_partner
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pwm_sd_pkg::*;
   logic        pclk    = 1'b0;  // Module clock
   logic        presetn = 1'b0;  // Reset, low
   logic        psel    = 1'b0;  // APB select
   logic        penable = 1'b0;  // APB access phase
   logic        pwrite  = 1'b0;  // APB direction
   logic [7:0]  paddr   = 8'h00; // APB address
   logic [31:0] pwdata  = 32'h0; // APB write data
   logic [4:0]  level   = 5'h00; // Source levels asked of the partner
   logic [31:0] prdata;          // Read data
   logic        pready;          // Ready
   logic        pslverr;         // Error
   logic [4:0]  src;             // Synchronized sources
   logic [5:0]  wave;            // Waveform into the block
   logic [5:0]  pwm_out;         // Power stage drive
   logic        sd_act;          // Shutdown held
   logic        per_ev;          // Period pulse
   logic        irq;             // Interrupt
   logic [15:0] tbc;             // Counter
   logic [15:0] ph;              // Phase
   logic [15:0] dc;              // Duty
   logic [15:0] pr;              // Period
   logic [31:0] rd;              // Last read data
   logic        err;             // Last error response
   int          n_fail = 0;      // Mismatches
   int          num_checks = 0;  // Comparisons

   // Clock at 50 MHz
   always #10 pclk = ~pclk;

   pwm_shutdown_timebase dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_trigger_input(src[4]),
      .comparator1_synced_out(src[0]), .comparator2_synced_out(src[1]),
      .comparator3_synced_out(src[2]), .comparator4_synced_out(src[3]),
      .pwm_in(wave), .pwm_out(pwm_out), .shutdown_active(sd_act),
      .period_event(per_ev), .time_base_counter(tbc), .phase_value(ph),
      .duty_value(dc), .period_value(pr), .irq(irq)
   );

   sd_partner far_side (
      .pclk(pclk), .presetn(presetn), .level(level), .src(src), .wave(wave)
   );

   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; the answer is taken at the edge that sees pready high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc

   // Reset values of the register table
   task t_reset;
      rdc(ADDR_SD_SRC, 32'h0);
      rdc(ADDR_TB_HIGH, 32'h1);
      for (int a = ADDR_PH_LOW; a <= ADDR_PER_HIGH; a += 4) rdc(8'(a), 32'h0);
      $display("test reset values done");
   endtask : t_reset

   // Byte halves, loose bits, counter access, unmapped place
   task t_regs;
      wr(ADDR_SD_SRC, 32'hffff_ffff);
      rdc(ADDR_SD_SRC, 32'h9e);
      for (int i = 0; i < 6; i++) wr(8'(ADDR_PH_LOW + 4 * i), {24'hffffff, 8'(8'h31 + 17 * i)});
      for (int i = 0; i < 6; i++) rdc(8'(ADDR_PH_LOW + 4 * i), {24'h0, 8'(8'h31 + 17 * i)});
      chk({16'h0, ph}, 32'h4231);
      chk({16'h0, dc}, 32'h6453);
      chk({16'h0, pr}, 32'h8675);
      wr(ADDR_TB_HIGH, 32'h12);
      wr(ADDR_TB_LOW, 32'h34);
      // One count lands between the write and the setup-edge capture
      rdc(ADDR_TB_LOW, 32'h35);
      rdc(ADDR_TB_HIGH, 32'h12);
      chk({24'h0, tbc[15:8]}, 32'h12);
      apb(1'b0, 8'h34, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("test registers done");
   endtask : t_regs

   // One source: enabled among all, then the only one disabled
   task t_source(input int i);
      logic [7:0] b;
      b = (i == 4) ? 8'h80 : 8'(8'h02 << i);
      wr(ADDR_SD_SRC, 32'h9e);
      level <= 5'(5'h01 << i);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, sd_act}, 32'h1);
      chk({26'h0, pwm_out}, 32'h2a);
      chk({31'h0, irq}, 32'h1);
      @(posedge pclk);
      level <= 5'h00;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, sd_act}, 32'h0);
      rdc(ADDR_IRQ_STATUS, 32'h1);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_SD_SRC, {24'h0, 8'h9e & ~b});
      level <= 5'(5'h01 << i);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, sd_act}, 32'h0);
      chk({26'h0, pwm_out}, {26'h0, wave - 6'h01});
      @(posedge pclk);
      level <= 5'h00;
      $display("test source %0d done", i);
   endtask : t_source

   // Without auto-restart only software ends the shutdown
   task t_manual;
      wr(ADDR_SD_CTRL, 32'h40);
      wr(ADDR_SD_SRC, 32'h80);
      level <= 5'h10;
      repeat (3) @(posedge pclk);
      level <= 5'h00;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, sd_act}, 32'h1);
      wr(ADDR_SD_CTRL, 32'h40);
      @(negedge pclk);
      chk({31'h0, sd_act}, 32'h0);
      rdc(ADDR_IRQ_STATUS, 32'h1);
      $display("test manual restart done");
   endtask : t_manual

   // Period match: counts 0..5 give events six cycles apart
   task t_period;
      logic [31:0] gap;
      wr(ADDR_PER_LOW, 32'h5);
      wr(ADDR_PER_HIGH, 32'h0);
      wr(ADDR_TB_HIGH, 32'h0);
      wr(ADDR_TB_LOW, 32'h0);
      wr(ADDR_SD_CTRL, 32'h01);
      chk({16'h0, pr}, 32'h5);
      // Shutdown switched off: the pin is still selected but must not act
      level <= 5'h10;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, sd_act}, 32'h0);
      chk({26'h0, pwm_out}, {26'h0, wave - 6'h01});
      @(posedge pclk);
      level <= 5'h00;
      for (int k = 0; k < 100 && per_ev !== 1'b1; k++) @(negedge pclk);
      gap = 32'h0;
      do begin
         @(negedge pclk);
         gap++;
      end while (per_ev !== 1'b1 && gap < 32'h64);
      chk(gap, 32'h6);
      $display("test period match done");
   endtask : t_period

   // Verdict in one place
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test

   // Main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_regs;
      wr(ADDR_SD_LEVEL, 32'h2a);
      wr(ADDR_IRQ_MASK, 32'h1);
      wr(ADDR_SD_CTRL, 32'h60);
      for (int i = 0; i < 5; i++) t_source(i);
      t_manual;
      t_period;
      stop_test;
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      stop_test;
   end
endmodule : tb_top
`default_nettype wire
